// ### hw/didr_pkg.sv
// Constants for the DRAM integrity, write buffer and decode register block
// Functional notes
// - Duration bit 0: error output pulses low one clock per reported error.
// - Duration bit 1: error output stays low until all error flags cleared.
// - Multi-bit/parity enable 0: no checking and no error signal for those errors.
// - Single-bit enable 0: no single-bit checking; 1: signal single-bit ECC errors.
// - Integrity mode bit: 0 selects parity, 1 selects ECC.
// - Multi-bit or parity error loads row field 7-5 and sets flag; the row loads only while flag bit 4 is clear.
// - Multi-bit/parity flag bit 4 set by hardware; write 1 clears, 0 ignored.
// - Single-bit error loads row field 3-1 and sets flag bit 0; the row loads only while flag bit 0 is clear.
// - Single-bit flag sets only in ECC mode; write 1 clears, 0 ignored.
// - Gated host clock keeps running 2, 4, 6 or 8 clocks after idle.
// - Write concurrency bit 1 blocks buffer cycles during PCI DRAM writes.
// - Read concurrency bit 1 blocks buffer cycles during PCI DRAM reads.
// - Idle flush timeout codes: 4, 8, 12, 16, 32 clocks; others reserved.
// - Idle flush enabled holds each line until its timer expires; else flush now.
// - 14M-15M local when hole bit 1 and memory exceeds 15M, else PCI.
// - 15M-16M local when hole bit 1 and memory exceeds 16M, else PCI.
// - Page A-B bit 1 sends A0000h-BFFFFh to DRAM, else PCI.
// - Force bit 1 sends 80000h-9FFFFh to PCI, else DRAM.
// - Split with region 01: only code fetches reach SMRAM, data goes to PCI.
// - Region field: 00 D000 to B000, 01 A000/B000, 10 3000 to B000.
// - Access control 0: SMRAM only inside SMI handler; 1: any time.
// - SMRAM remapping happens only while mapping enable is 1.
// - Region 00: remap D0000 to B0000 unless SMM inactive and control 0.
package didr_pkg;
    localparam logic [7:0] ADDR_FEATURE = 8'h50;
    localparam logic [7:0] ADDR_STATUS = 8'h51;
    localparam logic [7:0] ADDR_RSVD = 8'h52;
    localparam logic [7:0] ADDR_PWB = 8'h53;
    localparam logic [7:0] ADDR_HOLE = 8'h54;
    localparam logic [7:0] ADDR_SMRAM = 8'h55;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // Writable masks, reserved bits held at zero
    localparam logic [7:0] MASK_FEATURE = 8'h71;
    localparam logic [7:0] MASK_PWB = 8'hff;
    localparam logic [7:0] MASK_HOLE = 8'h3c;
    localparam logic [7:0] MASK_SMRAM = 8'h1f;
    // Feature fields
    localparam int F_DURATION = 6;
    localparam int F_MBIT_EN = 5;
    localparam int F_SBIT_EN = 4;
    localparam int F_ECC_MODE = 0;
    // Status fields
    localparam int S_MROW_LO = 5;
    localparam int S_MFLAG = 4;
    localparam int S_SROW_LO = 1;
    localparam int S_SFLAG = 0;
    // Posted write buffer fields
    localparam int P_HOLD_LO = 6;
    localparam int P_NO_WR_CONC = 5;
    localparam int P_NO_RD_CONC = 4;
    localparam int P_FLUSH_LO = 1;
    localparam int P_IDLE_DIS = 0;
    // Hole fields
    localparam int H_14M = 5;
    localparam int H_15M = 4;
    localparam int H_PAGE_AB = 3;
    localparam int H_FORCE_80 = 2;
    // SMRAM fields
    localparam int M_SPLIT = 4;
    localparam int M_REGION_LO = 2;
    localparam int M_ANYTIME = 1;
    localparam int M_MAP_EN = 0;
    localparam logic [1:0] REGION_D000 = 2'h0;
    localparam logic [1:0] REGION_AB = 2'h1;
    localparam logic [1:0] REGION_3000 = 2'h2;
    // Flush timeouts in clocks
    localparam logic [5:0] FLUSH_T0 = 6'h04;
    localparam logic [5:0] FLUSH_T1 = 6'h08;
    localparam logic [5:0] FLUSH_T2 = 6'h0c;
    localparam logic [5:0] FLUSH_T6 = 6'h10;
    localparam logic [5:0] FLUSH_T7 = 6'h20;
    localparam logic [2:0] FLUSH_C0 = 3'h0;
    localparam logic [2:0] FLUSH_C1 = 3'h1;
    localparam logic [2:0] FLUSH_C2 = 3'h2;
    localparam logic [2:0] FLUSH_C6 = 3'h6;
    localparam logic [2:0] FLUSH_C7 = 3'h7;
    localparam int NUM_LINES = 4;
    // Address map, 64 KB segments on bits 31:16
    localparam logic [15:0] SEG_3 = 16'h0003;
    localparam logic [15:0] SEG_8 = 16'h0008;
    localparam logic [15:0] SEG_9 = 16'h0009;
    localparam logic [15:0] SEG_A = 16'h000a;
    localparam logic [15:0] SEG_B = 16'h000b;
    localparam logic [15:0] SEG_D = 16'h000d;
    localparam logic [31:0] MEM_14M = 32'h00e0_0000;
    localparam logic [31:0] MEM_15M = 32'h00f0_0000;
    localparam logic [31:0] MEM_16M = 32'h0100_0000;
endpackage

// ### hw/didr_regs.sv
// DRAM integrity reporting, posted write buffer control and memory decode registers
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module didr_regs (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic err_multi,
    input wire logic err_single,
    input wire logic [2:0] err_row,
    output logic serr_n,
    output logic parity_check_en,
    output logic ecc_mbit_check_en,
    output logic ecc_sbit_check_en,
    input wire logic gate_clk_en,
    input wire logic host_busy,
    output logic host_clk_run,
    input wire logic pwb_req,
    input wire logic pci_dram_wr,
    input wire logic pci_dram_rd,
    output logic pwb_go,
    input wire logic [3:0] line_valid,
    input wire logic [3:0] line_write,
    output logic [3:0] line_flush,
    input wire logic cyc_valid,
    input wire logic [31:0] cyc_addr,
    input wire logic code_data_indicator,
    input wire logic smm_active_input_n,
    input wire logic [31:0] mem_top,
    output logic dec_valid,
    output logic dec_local,
    output logic dec_smram,
    output logic [31:0] dec_addr
);
    typedef struct packed {
        logic [7:0] feat;
        logic [7:0] stat;
        logic [7:0] pwb;
        logic [7:0] hole;
        logic [7:0] smm_ram_mapping;
        logic [7:0] rdata;
        logic serr_n;
        logic pchk;
        logic mchk;
        logic schk;
        logic [3:0] hold_cnt;
        logic clk_run;
        logic go;
        logic [3:0][5:0] tmr;
        logic [3:0] flush;
        logic dvalid;
        logic dlocal;
        logic dsmram;
        logic [31:0] daddr;
    } didr_state_s;

    didr_state_s st_ff;
    didr_state_s nxt_st;
    logic [5:0] flush_lim;
    logic [3:0] hold_lim;
    logic [3:0][5:0] tmr_nxt;
    logic [3:0] flush_nxt;

    always_comb begin
        case (st_ff.pwb[didr_pkg::P_FLUSH_LO +: 3])
            didr_pkg::FLUSH_C0: flush_lim = didr_pkg::FLUSH_T0;
            didr_pkg::FLUSH_C1: flush_lim = didr_pkg::FLUSH_T1;
            didr_pkg::FLUSH_C2: flush_lim = didr_pkg::FLUSH_T2;
            didr_pkg::FLUSH_C6: flush_lim = didr_pkg::FLUSH_T6;
            didr_pkg::FLUSH_C7: flush_lim = didr_pkg::FLUSH_T7;
            // Reserved codes fall back to the shortest timeout
            default: flush_lim = didr_pkg::FLUSH_T0;
        endcase
    end

    // 2, 4, 6 or 8 clocks
    assign hold_lim = {1'b0, st_ff.pwb[didr_pkg::P_HOLD_LO +: 2], 1'b0} + 4'h2;

    // Per-line idle timers; a write restarts the line's idle count
    genvar gi;
    generate
        for (gi = 0; gi < didr_pkg::NUM_LINES; gi++) begin : g_line
            always_comb begin
                tmr_nxt[gi] = st_ff.tmr[gi];
                flush_nxt[gi] = 1'b0;
                if (!line_valid[gi] || line_write[gi]) begin
                    tmr_nxt[gi] = 6'h00;
                end else if (st_ff.pwb[didr_pkg::P_IDLE_DIS]) begin
                    flush_nxt[gi] = 1'b1;
                end else if (st_ff.tmr[gi] >= flush_lim - 6'h01) begin
                    tmr_nxt[gi] = flush_lim;
                    flush_nxt[gi] = 1'b1;
                end else begin
                    tmr_nxt[gi] = st_ff.tmr[gi] + 6'h01;
                end
            end
        end
    endgenerate

    logic mbit_hit;
    logic sbit_hit;
    logic smm_ok;
    logic [1:0] region;
    logic [15:0] seg;

    always_comb begin
        nxt_st = st_ff;
        region = st_ff.smm_ram_mapping[didr_pkg::M_REGION_LO +: 2];
        seg = cyc_addr[31:16];
        // Checking is off altogether when the report enable is clear
        mbit_hit = err_multi & st_ff.feat[didr_pkg::F_MBIT_EN];
        sbit_hit = err_single & st_ff.feat[didr_pkg::F_SBIT_EN]
            & st_ff.feat[didr_pkg::F_ECC_MODE];
        smm_ok = st_ff.smm_ram_mapping[didr_pkg::M_ANYTIME] | ~smm_active_input_n;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                didr_pkg::ADDR_FEATURE: begin
                    nxt_st.feat = reg_wdata & didr_pkg::MASK_FEATURE;
                end
                didr_pkg::ADDR_STATUS: begin
                    if (reg_wdata[didr_pkg::S_MFLAG]) begin
                        nxt_st.stat[didr_pkg::S_MFLAG] = 1'b0;
                    end
                    if (reg_wdata[didr_pkg::S_SFLAG]) begin
                        nxt_st.stat[didr_pkg::S_SFLAG] = 1'b0;
                    end
                end
                didr_pkg::ADDR_PWB: nxt_st.pwb = reg_wdata & didr_pkg::MASK_PWB;
                didr_pkg::ADDR_HOLE: nxt_st.hole = reg_wdata & didr_pkg::MASK_HOLE;
                didr_pkg::ADDR_SMRAM: nxt_st.smm_ram_mapping = reg_wdata & didr_pkg::MASK_SMRAM;
                default: nxt_st.feat = st_ff.feat;
            endcase
        end

        // Hardware set wins over a same-cycle clear; row kept from first error
        if (mbit_hit) begin
            if (!st_ff.stat[didr_pkg::S_MFLAG]) begin
                nxt_st.stat[didr_pkg::S_MROW_LO +: 3] = err_row;
            end
            nxt_st.stat[didr_pkg::S_MFLAG] = 1'b1;
        end
        if (sbit_hit) begin
            if (!st_ff.stat[didr_pkg::S_SFLAG]) begin
                nxt_st.stat[didr_pkg::S_SROW_LO +: 3] = err_row;
            end
            nxt_st.stat[didr_pkg::S_SFLAG] = 1'b1;
        end

        // Error output
        if (st_ff.feat[didr_pkg::F_DURATION]) begin
            nxt_st.serr_n = ~(nxt_st.stat[didr_pkg::S_MFLAG]
                | nxt_st.stat[didr_pkg::S_SFLAG]);
        end else begin
            nxt_st.serr_n = ~(mbit_hit | sbit_hit);
        end

        // Checker enables registered with the feature byte, so no decode glitch
        nxt_st.pchk = nxt_st.feat[didr_pkg::F_MBIT_EN]
            & ~nxt_st.feat[didr_pkg::F_ECC_MODE];
        nxt_st.mchk = nxt_st.feat[didr_pkg::F_MBIT_EN]
            & nxt_st.feat[didr_pkg::F_ECC_MODE];
        nxt_st.schk = nxt_st.feat[didr_pkg::F_SBIT_EN]
            & nxt_st.feat[didr_pkg::F_ECC_MODE];

        // Read data valid only in the cycle after the strobe
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                didr_pkg::ADDR_FEATURE: nxt_st.rdata = st_ff.feat;
                didr_pkg::ADDR_STATUS: nxt_st.rdata = st_ff.stat;
                didr_pkg::ADDR_PWB: nxt_st.rdata = st_ff.pwb;
                didr_pkg::ADDR_HOLE: nxt_st.rdata = st_ff.hole;
                didr_pkg::ADDR_SMRAM: nxt_st.rdata = st_ff.smm_ram_mapping;
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // Gated host clock hold after idle
        if (!gate_clk_en || host_busy) begin
            nxt_st.hold_cnt = 4'h0;
            nxt_st.clk_run = 1'b1;
        end else if (st_ff.hold_cnt < hold_lim) begin
            nxt_st.hold_cnt = st_ff.hold_cnt + 4'h1;
            nxt_st.clk_run = 1'b1;
        end else begin
            nxt_st.clk_run = 1'b0;
        end

        // Buffer cycles held off by PCI traffic when concurrency disabled
        nxt_st.go = pwb_req
            & ~(st_ff.pwb[didr_pkg::P_NO_WR_CONC] & pci_dram_wr)
            & ~(st_ff.pwb[didr_pkg::P_NO_RD_CONC] & pci_dram_rd);

        nxt_st.tmr = tmr_nxt;
        nxt_st.flush = flush_nxt;

        // Address decode, one clock of latency
        nxt_st.dvalid = cyc_valid;
        nxt_st.dsmram = 1'b0;
        nxt_st.daddr = cyc_addr;
        nxt_st.dlocal = cyc_addr < mem_top;
        if (seg == didr_pkg::SEG_8 || seg == didr_pkg::SEG_9) begin
            nxt_st.dlocal = ~st_ff.hole[didr_pkg::H_FORCE_80];
        end else if (seg == didr_pkg::SEG_A || seg == didr_pkg::SEG_B) begin
            nxt_st.dlocal = st_ff.hole[didr_pkg::H_PAGE_AB];
        end else if (cyc_addr >= didr_pkg::MEM_14M && cyc_addr < didr_pkg::MEM_15M) begin
            nxt_st.dlocal = st_ff.hole[didr_pkg::H_14M]
                & (mem_top > didr_pkg::MEM_15M);
        end else if (cyc_addr >= didr_pkg::MEM_15M && cyc_addr < didr_pkg::MEM_16M) begin
            nxt_st.dlocal = st_ff.hole[didr_pkg::H_15M]
                & (mem_top > didr_pkg::MEM_16M);
        end
        // SMRAM overrides the plain decode only while mapping is on
        if (st_ff.smm_ram_mapping[didr_pkg::M_MAP_EN]) begin
            case (region)
                didr_pkg::REGION_D000: begin
                    if (seg == didr_pkg::SEG_D) begin
                        nxt_st.dlocal = smm_ok;
                        nxt_st.dsmram = smm_ok;
                        if (smm_ok) begin
                            nxt_st.daddr = {didr_pkg::SEG_B, cyc_addr[15:0]};
                        end
                    end
                end
                didr_pkg::REGION_AB: begin
                    if (seg == didr_pkg::SEG_A || seg == didr_pkg::SEG_B) begin
                        // Data cycles skip SMRAM under the split
                        if (smm_ok
                            && !(st_ff.smm_ram_mapping[didr_pkg::M_SPLIT] && code_data_indicator)) begin
                            nxt_st.dlocal = 1'b1;
                            nxt_st.dsmram = 1'b1;
                        end else begin
                            nxt_st.dlocal = 1'b0;
                        end
                    end
                end
                didr_pkg::REGION_3000: begin
                    // Outside SMM with access control 0 the segment stays plain DRAM
                    if (seg == didr_pkg::SEG_3 && smm_ok) begin
                        nxt_st.dlocal = 1'b1;
                        nxt_st.dsmram = 1'b1;
                        nxt_st.daddr = {didr_pkg::SEG_B, cyc_addr[15:0]};
                    end
                end
                default: nxt_st.dsmram = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.feat <= didr_pkg::RESET_VAL;
            st_ff.stat <= didr_pkg::RESET_VAL;
            st_ff.pwb <= didr_pkg::RESET_VAL;
            st_ff.hole <= didr_pkg::RESET_VAL;
            st_ff.smm_ram_mapping <= didr_pkg::RESET_VAL;
            st_ff.serr_n <= 1'b1;
            st_ff.clk_run <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign serr_n = st_ff.serr_n;
    // Parity vs ECC checker selection
    assign parity_check_en = st_ff.pchk;
    assign ecc_mbit_check_en = st_ff.mchk;
    assign ecc_sbit_check_en = st_ff.schk;
    assign host_clk_run = st_ff.clk_run;
    assign pwb_go = st_ff.go;
    assign line_flush = st_ff.flush;
    assign dec_valid = st_ff.dvalid;
    assign dec_local = st_ff.dlocal;
    assign dec_smram = st_ff.dsmram;
    assign dec_addr = st_ff.daddr;
endmodule

// ### sim/didr_assertions.sv
// Port-level checks for the integrity, buffer and decode registers
`timescale 1ns/1ns
module didr_assertions (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic err_multi,
    input wire logic err_single,
    input wire logic serr_n,
    input wire logic parity_check_en,
    input wire logic ecc_mbit_check_en,
    input wire logic ecc_sbit_check_en,
    input wire logic pci_dram_wr,
    input wire logic pci_dram_rd,
    input wire logic pwb_go,
    input wire logic cyc_valid,
    input wire logic [31:0] cyc_addr,
    input wire logic dec_valid,
    input wire logic dec_local,
    input wire logic dec_smram
);
    // Shadows rebuilt from bus writes, so checks never peek inside
    logic [7:0] feat_ff, pwb_ff, hole_ff, smr_ff;
    always_ff @(posedge mclk) begin
        if (srst) begin
            feat_ff <= 8'h00;
            pwb_ff <= 8'h00;
            hole_ff <= 8'h00;
            smr_ff <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                didr_pkg::ADDR_FEATURE: feat_ff <= reg_wdata;
                didr_pkg::ADDR_PWB: pwb_ff <= reg_wdata;
                didr_pkg::ADDR_HOLE: hole_ff <= reg_wdata;
                didr_pkg::ADDR_SMRAM: smr_ff <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_mbit_err;
        feat_ff[5] && err_multi;
    endsequence
    sequence s_quiet;
        !feat_ff[6] && !err_multi && !err_single;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside a read cycle");
    a_feat_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h50
        |-> reg_rdata == ($past(feat_ff) & 8'h71)) else $error("feature readback wrong");
    a_mbit_off: assert property (!feat_ff[5] |-> !parity_check_en && !ecc_mbit_check_en)
        else $error("multi-bit checking while disabled");
    a_sbit_off: assert property (!(feat_ff[4] && feat_ff[0]) |-> !ecc_sbit_check_en)
        else $error("single-bit checking while disabled");
    a_mode_sel: assert property (feat_ff[5] |-> parity_check_en == !feat_ff[0]
        && ecc_mbit_check_en == feat_ff[0]) else $error("wrong integrity scheme");
    a_serr_set: assert property (s_mbit_err |=> !serr_n)
        else $error("error not signalled");
    a_serr_pulse: assert property (s_quiet |=> serr_n)
        else $error("error signal longer than a pulse");
    a_no_wr_conc: assert property (pci_dram_wr && pwb_ff[5] |=> !pwb_go)
        else $error("buffer cycle beside PCI write");
    a_no_rd_conc: assert property (pci_dram_rd && pwb_ff[4] |=> !pwb_go)
        else $error("buffer cycle beside PCI read");
    a_force_pci: assert property (cyc_valid && cyc_addr[31:17] == 15'h0004 && hole_ff[2]
        && !smr_ff[0] |=> dec_valid && !dec_local) else $error("low region not forwarded");
    a_smram_off: assert property (cyc_valid && !smr_ff[0] |=> !dec_smram)
        else $error("SMRAM hit while mapping off");
endmodule

// ### sim/didr_partner.sv
// Far-side error detector model: one-cycle error pulses with the failing row
`timescale 1ns/1ns
module didr_partner (
    input wire logic mclk,
    input wire logic kick_m,
    input wire logic kick_s,
    input wire logic [2:0] kick_row,
    output logic err_multi = 1'h0,
    output logic err_single = 1'h0,
    output logic [2:0] err_row = 3'h0
);
    // Row is only meaningful with a pulse; it churns otherwise
    always_ff @(posedge mclk) begin
        err_multi <= kick_m;
        err_single <= kick_s;
        err_row <= (kick_m || kick_s) ? kick_row : ~err_row;
    end
endmodule

// ### sim/test_dram_integrity_decode_regs.sv
// Self-checking bench for the integrity, buffer and decode registers
`timescale 1ns/1ns
module test_dram_integrity_decode_regs;
    localparam logic [31:0] MTOP = 32'h0200_0000;
    logic mclk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic err_multi, err_single, serr_n, kick_m = 1'h0, kick_s = 1'h0;
    logic [2:0] err_row, kick_row = 3'h0;
    logic parity_check_en, ecc_mbit_check_en, ecc_sbit_check_en, host_clk_run, pwb_go;
    logic gate_clk_en = 1'h0, host_busy = 1'h0, pwb_req = 1'h0, pci_dram_wr = 1'h0;
    logic pci_dram_rd = 1'h0, cyc_valid = 1'h0, code_data_indicator = 1'h0;
    logic smm_active_input_n = 1'h1, dec_valid, dec_local, dec_smram;
    logic [3:0] line_valid = 4'h0, line_write = 4'h0, line_flush;
    logic [31:0] cyc_addr = 32'h0, mem_top = 32'h0, dec_addr;
    int n_mismatch = 0, checked = 0, n;
    always #20 mclk = ~mclk;
    didr_partner u_far (.mclk, .kick_m, .kick_s, .kick_row, .err_multi, .err_single, .err_row);
    didr_regs u_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .err_multi, .err_single, .err_row, .serr_n, .parity_check_en, .ecc_mbit_check_en,
        .ecc_sbit_check_en, .gate_clk_en, .host_busy, .host_clk_run, .pwb_req, .pci_dram_wr,
        .pci_dram_rd, .pwb_go, .line_valid, .line_write, .line_flush, .cyc_valid, .cyc_addr,
        .code_data_indicator, .smm_active_input_n, .mem_top, .dec_valid, .dec_local,
        .dec_smram, .dec_addr);
    task results;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tmo(input int lim);
        if (n > lim) begin
            n_mismatch++;
            results;
        end
    endtask
    task rst;
        @(posedge mclk) srst <= 1'h1;
        repeat (2) @(posedge mclk);
        srst <= 1'h0;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
        @(posedge mclk) reg_wr <= 1'h0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'h1};
        @(posedge mclk) reg_rd <= 1'h0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    task inj(input logic m, s, input logic [2:0] r);
        @(posedge mclk) {kick_m, kick_s, kick_row} <= {m, s, r};
        @(posedge mclk) {kick_m, kick_s} <= 2'h0;
    endtask
    task t_regs;
        logic [7:0] ad[5] = '{8'h50, 8'h52, 8'h53, 8'h54, 8'h55};
        logic [7:0] mk[5] = '{8'h71, 8'h00, 8'hff, 8'h3c, 8'h1f};
        for (int i = 0; i < 6; i++)
            rd(8'h50 + 8'(i), 8'h00);
        rd(8'h60, 8'h00);
        // Read right after write catches a lost or late update
        for (int i = 0; i < 5; i++) begin
            wr(ad[i], 8'hff);
            rd(ad[i], mk[i]);
        end
        rst;
    endtask
    task t_pulse;
        wr(8'h50, 8'h21);
        #1 chk("en", {parity_check_en, ecc_mbit_check_en, ecc_sbit_check_en}, 3'h2);
        inj(1'h1, 1'h0, 3'h5);
        @(posedge mclk) #1 chk("serr_n", serr_n, 1'h0);
        @(posedge mclk) #1 chk("serr_n", serr_n, 1'h1);
        rd(8'h51, 8'hb0);
        inj(1'h1, 1'h0, 3'h3);
        rd(8'h51, 8'hb0);
        wr(8'h51, 8'h00);
        rd(8'h51, 8'hb0);
        wr(8'h51, 8'h10);
        inj(1'h1, 1'h0, 3'h2);
        rd(8'h51, 8'h50);
        rst;
    endtask
    task t_level;
        wr(8'h50, 8'h51);
        #1 chk("en", {parity_check_en, ecc_mbit_check_en, ecc_sbit_check_en}, 3'h1);
        inj(1'h0, 1'h1, 3'h2);
        repeat (4) @(posedge mclk);
        #1 chk("serr_n", serr_n, 1'h0);
        rd(8'h51, 8'h05);
        wr(8'h51, 8'h00);
        #1 chk("serr_n", serr_n, 1'h0);
        wr(8'h51, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("serr_n", serr_n, 1'h1);
        rst;
    endtask
    task t_off;
        inj(1'h1, 1'h1, 3'h7);
        repeat (2) @(posedge mclk);
        #1 chk("serr_n", serr_n, 1'h1);
        rd(8'h51, 8'h00);
        wr(8'h50, 8'h30);
        #1 chk("en", {parity_check_en, ecc_mbit_check_en, ecc_sbit_check_en}, 3'h4);
        inj(1'h0, 1'h1, 3'h7);
        rd(8'h51, 8'h00);
        inj(1'h1, 1'h0, 3'h7);
        rd(8'h51, 8'hf0);
        rst;
    endtask
    task t_hold;
        gate_clk_en <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h53, {2'(c), 6'h00});
            @(posedge mclk) host_busy <= 1'h1;
            @(posedge mclk) host_busy <= 1'h0;
            for (n = 0; n < 20; n++)
                @(posedge mclk) #1 if (host_clk_run !== 1'h1) break;
            tmo(19);
            chk("hold cycles", n, 2 * (c + 1));
        end
    endtask
    task t_flush;
        logic [3:0] cd[7] = '{4'h0, 4'h2, 4'h4, 4'hc, 4'he, 4'h6, 4'h1};
        int ft[7] = '{4, 8, 12, 16, 32, 4, 1};
        for (int i = 0; i < 7; i++) begin
            wr(8'h53, {4'h0, cd[i]});
            @(posedge mclk) {line_valid[0], line_write[0]} <= 2'h3;
            @(posedge mclk) line_write[0] <= 1'h0;
            for (n = 1; n < 40; n++)
                @(posedge mclk) #1 if (line_flush[0] === 1'h1) break;
            tmo(39);
            chk("flush delay", n, ft[i]);
            chk("line_flush", line_flush, 4'h1);
            @(posedge mclk) line_valid[0] <= 1'h0;
        end
    endtask
    task t_conc;
        pwb_req <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            wr(8'h53, {2'h0, 2'(i), 4'h1});
            @(posedge mclk) {pci_dram_wr, pci_dram_rd} <= {~i[2], i[2]};
            @(posedge mclk) #1;
            chk("pwb_go", pwb_go, !(i[1] && !i[2]) && !(i[0] && i[2]));
        end
    endtask
    // Flags are {code_data, smm_n, local, smram}
    task dc(input logic [7:0] h, s, input logic [31:0] a, input logic [3:0] f,
        input logic [31:0] top, da);
        wr(8'h54, h);
        wr(8'h55, s);
        @(posedge mclk);
        {cyc_valid, cyc_addr, code_data_indicator, smm_active_input_n} <= {1'h1, a, f[3:2]};
        mem_top <= top;
        @(posedge mclk) cyc_valid <= 1'h0;
        #1 chk("decode", {dec_valid, dec_local, dec_smram}, {1'h1, f[1:0]});
        if (f[0])
            chk("dec_addr", dec_addr, da);
    endtask
    task t_dec;
        dc(8'h04, 8'h00, 32'h0008_0000, 4'h4, MTOP, 32'h0);
        dc(8'h00, 8'h00, 32'h0009_0000, 4'h6, MTOP, 32'h0);
        dc(8'h08, 8'h00, 32'h000b_0000, 4'h6, MTOP, 32'h0);
        dc(8'h00, 8'h00, 32'h000a_0000, 4'h4, MTOP, 32'h0);
        dc(8'h20, 8'h00, 32'h00e0_0000, 4'h6, MTOP, 32'h0);
        dc(8'h20, 8'h00, 32'h00e0_0000, 4'h4, 32'h00f0_0000, 32'h0);
        dc(8'h00, 8'h00, 32'h00e8_0000, 4'h4, MTOP, 32'h0);
        dc(8'h10, 8'h00, 32'h00f0_0000, 4'h4, 32'h0100_0000, 32'h0);
        dc(8'h10, 8'h00, 32'h00f0_0000, 4'h6, MTOP, 32'h0);
        dc(8'h00, 8'h01, 32'h000d_1234, 4'h3, MTOP, 32'h000b_1234);
        dc(8'h00, 8'h01, 32'h000d_1234, 4'h4, MTOP, 32'h0);
        dc(8'h00, 8'h03, 32'h000d_1234, 4'h7, MTOP, 32'h000b_1234);
        dc(8'h00, 8'h00, 32'h000d_1234, 4'h2, MTOP, 32'h0);
        dc(8'h00, 8'h05, 32'h000a_0100, 4'h3, MTOP, 32'h000a_0100);
        dc(8'h00, 8'h05, 32'h000a_0100, 4'h4, MTOP, 32'h0);
        dc(8'h00, 8'h15, 32'h000a_0100, 4'h8, MTOP, 32'h0);
        dc(8'h00, 8'h15, 32'h000b_0100, 4'h3, MTOP, 32'h000b_0100);
        dc(8'h00, 8'h09, 32'h0003_0010, 4'h3, MTOP, 32'h000b_0010);
        dc(8'h00, 8'h09, 32'h0003_0010, 4'h6, MTOP, 32'h0);
        dc(8'h00, 8'h0d, 32'h000d_1234, 4'h2, MTOP, 32'h0);
    endtask
    initial begin
        rst;
        t_regs;
        t_pulse;
        t_level;
        t_off;
        t_hold;
        t_flush;
        t_conc;
        t_dec;
        results;
    end
endmodule
bind didr_regs didr_assertions u_chk (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .err_multi, .err_single, .serr_n, .parity_check_en, .ecc_mbit_check_en,
    .ecc_sbit_check_en, .pci_dram_wr, .pci_dram_rd, .pwb_go, .cyc_valid, .cyc_addr,
    .dec_valid, .dec_local, .dec_smram);
